// ---- dv/dsci_ctrl_model.sv ----
// Controller model: link clock, commands and write beats.
`timescale 1ns/1ps
module dsci_ctrl_model (
   // System clock.
   input  wire         sys_clk_i,
   // Link pins toward the device.
   output logic        ck_o,
   output logic        ck_n_o,
   output logic        cke_o,
   output logic        cs_n_o,
   output logic        ras_n_o,
   output logic        cas_n_o,
   output logic        we_n_o,
   output logic [1:0]  ba_o,
   output logic [12:0] addr_o,
   output logic [15:0] dq_o,
   output logic [1:0]  dqs_o
);
   logic [2:0] ph = 3'h0;
   // Link clock of eight system cycles per period.
   always @(posedge sys_clk_i) begin
      ph <= ph + 3'h1;
      ck_o <= ph[2];
      ck_n_o <= ~ph[2];
   end
   // Pins idle at time zero.
   initial begin
      {ck_o, ck_n_o, cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o} = 7'h2F;
      {ba_o, addr_o, dq_o, dqs_o} = 33'h0;
   end
   // Command set while clock low, then a no-op.
   task automatic cmd(input logic [3:0] c, input logic [1:0] b,
      input logic [12:0] a, input logic e);
      do @(posedge sys_clk_i); while (ph !== 3'h2);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= c;
      {ba_o, addr_o, cke_o} <= {b, a, e};
      do @(posedge sys_clk_i); while (ph !== 3'h0);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'h7;
   endtask
   // One beat: data first, strobe edge in mid-beat.
   task automatic beat(input logic [15:0] d);
      dq_o <= d;
      repeat (2) @(posedge sys_clk_i);
      dqs_o <= ~dqs_o;
      repeat (2) @(posedge sys_clk_i);
   endtask
   // Released data lines show the inverted last value.
   task automatic rel;
      dq_o <= ~dq_o;
   endtask
endmodule // dsci_ctrl_model

// ---- dv/dsci_top_assertions.sv ----
// Port assertions for the DDR2 command interface.
`timescale 1ns/1ps
module dsci_top_assertions (
   // Clock, reset and burst setting.
   input wire        sys_clk_i,
   input wire        resetn_i,
   input wire        burst8_i,
   // Read data and strobes.
   input wire [15:0] dq_o,
   input wire        dq_oe_o,
   input wire [1:0]  dqs_o,
   input wire [1:0]  dqs_n_o,
   input wire        dqs_oe_o,
   // Status.
   input wire [3:0]  bank_open_o,
   input wire        suspended_o,
   input wire        pdown_o,
   input wire        sref_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   // Strobe shape, beat timing, burst length and power states.
   dqs_pair_a: assert property (dqs_oe_o |-> dqs_n_o == ~dqs_o)
      else $error("strobe pair not complementary");
   oe_match_a: assert property (dq_oe_o == dqs_oe_o)
      else $error("data and strobe enables differ");
   first_beat_a: assert property ($rose(dqs_oe_o) |->
      (dqs_o == 2'h3) [*4] ##1 (dqs_o == 2'h0)) else $error("bad strobe");
   beat_hold_a: assert property (dq_oe_o && $changed(dq_o) |=>
      $stable(dq_o) [*3]) else $error("read beat too short");
   burst4_len_a: assert property ($rose(dq_oe_o) && !burst8_i |->
      ##15 dq_oe_o ##1 !dq_oe_o) else $error("four-beat burst length");
   burst8_len_a: assert property ($rose(dq_oe_o) && burst8_i |->
      ##31 dq_oe_o ##1 !dq_oe_o) else $error("eight-beat burst length");
   idle_power_a: assert property (pdown_o || sref_o |->
      bank_open_o == 4'h0 && suspended_o && !(pdown_o && sref_o))
      else $error("power state with open bank");
   frozen_out_a: assert property (suspended_o [*6] |->
      $stable(dq_o) && $stable(dqs_o)) else $error("outputs moved");
   cover property ($rose(pdown_o));
   cover property ($rose(sref_o));
   cover property ($rose(dq_oe_o) && burst8_i);
endmodule // dsci_top_assertions

bind dsci_top dsci_top_assertions chk_u (.sys_clk_i(sys_clk_i),
   .resetn_i(resetn_i), .burst8_i(burst8_i), .dq_o(dq_o),
   .dq_oe_o(dq_oe_o), .dqs_o(dqs_o), .dqs_n_o(dqs_n_o),
   .dqs_oe_o(dqs_oe_o), .bank_open_o(bank_open_o),
   .suspended_o(suspended_o), .pdown_o(pdown_o), .sref_o(sref_o));

// ---- dv/dsci_top_test.sv ----
// Self-checking bench for the DDR2 command interface.
`timescale 1ns/1ps
`include "dsci_consts.vh"
module dsci_top_test;
   logic        sys_clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        ck_i, ck_n_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i;
   logic        dq_oe_o, dqs_oe_o, suspended_o, pdown_o, sref_o;
   logic [1:0]  ba_i, dqs_i, dqs_o, dqs_n_o;
   logic [12:0] addr_i;
   logic [15:0] dq_i, dq_o;
   logic [3:0]  bank_open_o;
   logic        burst8_i = 1'b1;
   logic        interleave_i = 1'b0;
   logic [2:0]  add_lat_i = 3'h0;
   logic [2:0]  cas_lat_i = 3'h3;
   logic [15:0] mem [8];
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          l0, l1;
   // Clock, controller model and device.
   always #10 sys_clk_i = ~sys_clk_i;
   dsci_ctrl_model m (.sys_clk_i, .ck_o(ck_i), .ck_n_o(ck_n_i),
      .cke_o(cke_i), .cs_n_o(cs_n_i), .ras_n_o(ras_n_i), .cas_n_o(cas_n_i),
      .we_n_o(we_n_i), .ba_o(ba_i), .addr_o(addr_i), .dq_o(dq_i),
      .dqs_o(dqs_i));
   dsci_top dut_u (.sys_clk_i, .resetn_i, .ce_i(1'b1), .ck_i, .ck_n_i,
      .cke_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i, .ba_i, .addr_i,
      .dm_i(2'h0), .dq_i, .dq_o, .dq_oe_o, .dqs_i, .dqs_o, .dqs_n_o,
      .dqs_oe_o, .burst8_i, .interleave_i, .add_lat_i, .cas_lat_i,
      .bank_open_o, .suspended_o, .pdown_o, .sref_o);
   // Comparison, status packing and burst order.
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   function automatic logic [15:0] st();
      return {9'h0, bank_open_o, pdown_o, sref_o, suspended_o};
   endfunction
   function automatic logic [2:0] ord(input logic [2:0] c, input int k);
      logic [2:0] mk;
      mk = burst8_i ? 3'h7 : 3'h3;
      if (interleave_i) return c ^ k[2:0];
      return (c & ~mk) | ((c + k[2:0]) & mk);
   endfunction
   // Command, then status check once it has landed.
   task automatic cw(input logic [3:0] c, input logic [1:0] b,
      input logic e, input logic [15:0] x);
      m.cmd(c, b, 13'h0, e);
      repeat (6) @(negedge sys_clk_i);
      chk(st(), x);
   endtask
   // Read from bank 2, measuring latency and checking every beat.
   task automatic rd(input logic [2:0] c, input logic ap, output int lat);
      lat = 0;
      m.cmd({1'b0, `DSCI_CMD_RD}, 2'h2, {2'h0, ap, 7'h0, c}, 1'b1);
      while (dq_oe_o !== 1'b1 && lat < 400) begin
         @(negedge sys_clk_i);
         lat++;
      end
      chk({15'h0, dq_oe_o}, 16'h0001);
      repeat (2) @(negedge sys_clk_i);
      for (int k = 0; k < (burst8_i ? 8 : 4); k++) begin
         chk(dq_o, mem[ord(c, k)]);
         repeat (4) @(negedge sys_clk_i);
      end
   endtask
   // Write to bank 2, beats starting once write latency has passed.
   task automatic wr(input logic [2:0] c, input logic [15:0] d);
      m.cmd({1'b0, `DSCI_CMD_WR}, 2'h2, {10'h0, c}, 1'b1);
      repeat (8 * (add_lat_i + cas_lat_i - 1)) @(posedge sys_clk_i);
      for (int k = 0; k < (burst8_i ? 8 : 4); k++) begin
         m.beat(d + 16'(k));
         mem[ord(c, k)] = d + 16'(k);
      end
      m.rel();
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Watchdog against a hung run.
   initial begin
      repeat (10000) @(posedge sys_clk_i);
      n_mismatch++;
      end_of_test();
   end
   // Main sequence.
   initial begin
      repeat (12) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      @(negedge sys_clk_i);
      chk(st(), 16'h0001);
      m.cmd(4'h7, 2'h0, 13'h0, 1'b1);
      cw(4'h7, 2'h0, 1'b1, 16'h0000);
      cw({1'b1, `DSCI_CMD_ACT}, 2'h1, 1'b1, 16'h0000);
      cw({1'b0, `DSCI_CMD_ACT}, 2'h2, 1'b1, 16'h0020);
      cw({1'b0, `DSCI_CMD_ACT}, 2'h1, 1'b1, 16'h0030);
      $display("bank test done");
      wr(3'h0, 16'hA0A0);
      rd(3'h0, 1'b0, l0);
      for (int i = 0; i < 2; i++) begin
         @(posedge sys_clk_i);
         burst8_i <= 1'b0;
         interleave_i <= i[0];
         rd(3'h5, 1'b0, l0);
      end
      for (int a = 2; a <= 6; a += 4) begin
         @(posedge sys_clk_i);
         add_lat_i <= a[2:0];
         rd(3'h0, 1'b0, l1);
         chk(16'(l1 - l0), 16'(8 * a));
      end
      @(posedge sys_clk_i);
      add_lat_i <= 3'h0;
      rd(3'h1, 1'b1, l1);
      repeat (12) @(negedge sys_clk_i);
      chk(st(), 16'h0010);
      cw({1'b0, `DSCI_CMD_PRE}, 2'h1, 1'b1, 16'h0000);
      $display("access test done");
      cw(4'h7, 2'h0, 1'b0, 16'h0005);
      cw({1'b0, `DSCI_CMD_ACT}, 2'h0, 1'b0, 16'h0005);
      cw(4'h7, 2'h0, 1'b1, 16'h0000);
      cw({1'b0, `DSCI_CMD_ACT}, 2'h3, 1'b1, 16'h0040);
      cw({1'b0, `DSCI_CMD_PRE}, 2'h3, 1'b1, 16'h0000);
      cw({1'b0, `DSCI_CMD_REF}, 2'h0, 1'b0, 16'h0003);
      cw(4'h7, 2'h0, 1'b1, 16'h0000);
      $display("power test done");
      end_of_test();
   end
endmodule // dsci_top_test

// ---- verilog/dsci_consts.vh ----
// Constants for the DDR2 command interface block.
`ifndef DSCI_CONSTS_VH
`define DSCI_CONSTS_VH
// Command codes, RAS/CAS/WE active low, chip select low.
`define DSCI_CMD_ACT      3'h3
`define DSCI_CMD_PRE      3'h2
`define DSCI_CMD_RD       3'h5
`define DSCI_CMD_WR       3'h4
`define DSCI_CMD_REF      3'h1
// Address bit requesting auto precharge or precharge of all banks.
`define DSCI_AP_BIT       10
// Burst lengths in beats.
`define DSCI_BL4          4'h4
`define DSCI_BL8          4'h8
// Largest additive latency in clock cycles.
`define DSCI_AL_MAX       3'h6
// Width of the synchronised pin bundle.
`define DSCI_SYNC_W       41
// Access sequencer states.
`define DSCI_ST_IDLE      2'h0
`define DSCI_ST_WAIT      2'h1
`define DSCI_ST_BURST     2'h2
// Number of banks and data storage words.
`define DSCI_BANKS        4
`define DSCI_WORDS        8
`endif

// ---- verilog/dsci_top.v ----
// Device-side command decoder, bank tracker and burst engine for DDR2.
`timescale 1ns/1ps
`include "dsci_consts.vh"

// Operation
// [RULE1] Sample control and address when CK rises and CK# falls.
// [RULE2] Read data beats advance on both CK crossing directions.
// [RULE3] Data strobes travel with data in both directions.
// [RULE4] Controller multiplexes row and column over one address bus.
// [RULE5] Controller activates a row before reading or writing that bank.
// [RULE6] Bursts are four or eight beats from the addressed column.
// [RULE7] Sequential or interleaved column order inside a burst.
// [RULE8] Auto precharge closes the row when the burst ends.
// [RULE9] Additive latency zero to six cycles posts read and write.
// [RULE10] Write latency is read latency minus one.
// [RULE11] CKE low suspends clock next cycle, freezing outputs and burst.
// [RULE12] CKE low with all banks idle enters power-down or self refresh.
// [RULE13] Bank address bits select the bank of each command.
// [RULE14] Four banks each hold their own open row.
// [RULE15] Controller refreshes 8192 times within each 64 ms.
// [RULE16] Chip select high masks all commands.
// [RULE17] RAS low CAS high: WE high activates, WE low precharges.
// [RULE18] Column from A0-A8, A10 auto precharge, row from A0-A12; the code takes the column from A0-A2 only.
// [RULE19] No decoding while suspended; resume one cycle after CKE high.
module dsci_top (
   // Clock, reset and clock enable.
   input  wire        sys_clk_i,
   input  wire        resetn_i,
   input  wire        ce_i,
   // Memory link pins.
   input  wire        ck_i,
   input  wire        ck_n_i,
   input  wire        cke_i,
   input  wire        cs_n_i,
   input  wire        ras_n_i,
   input  wire        cas_n_i,
   input  wire        we_n_i,
   input  wire [1:0]  ba_i,
   input  wire [12:0] addr_i,
   input  wire [1:0]  dm_i,
   input  wire [15:0] dq_i,
   output reg  [15:0] dq_o,
   output reg         dq_oe_o,
   input  wire [1:0]  dqs_i,
   output reg  [1:0]  dqs_o,
   output reg  [1:0]  dqs_n_o,
   output reg         dqs_oe_o,
   // Configuration.
   input  wire        burst8_i,
   input  wire        interleave_i,
   input  wire [2:0]  add_lat_i,
   input  wire [2:0]  cas_lat_i,
   // Status.
   output reg  [3:0]  bank_open_o,
   output reg         suspended_o,
   output reg         pdown_o,
   output reg         sref_o
);

   // Pin synchroniser and sampled copies.
   reg  [`DSCI_SYNC_W-1:0] meta_reg;
   reg  [`DSCI_SYNC_W-1:0] sync_reg;
   reg         ckx_prev_reg;
   reg         dqs_prev_reg;
   reg         cke_q_reg;
   reg  [1:0]  state_reg;
   reg  [3:0]  lat_reg;
   reg  [3:0]  beat_reg;
   reg         is_rd_reg;
   reg         ap_reg;
   reg  [1:0]  bank_reg;
   reg  [2:0]  col_reg;
   reg  [15:0] mem_reg [0:`DSCI_WORDS-1];
   reg  [3:0]  bank_open_reg;
   reg  [12:0] row_reg [0:`DSCI_BANKS-1];

   wire [15:0] s_dq    = sync_reg[15:0];
   wire [1:0]  s_dm    = sync_reg[17:16];
   wire        s_dqs   = sync_reg[18];
   wire [12:0] s_addr  = sync_reg[31:19];
   wire [1:0]  s_ba    = sync_reg[33:32];
   wire [2:0]  s_cmd   = sync_reg[36:34];
   wire        s_cs_n  = sync_reg[37];
   wire        s_cke   = sync_reg[38];
   wire        s_ckx   = sync_reg[39] & ~sync_reg[40];

   // Crossing point detection on the differential pair.
   // [RULE1] crossing point sampling
   wire ck_rise = ce_i & s_ckx & ~ckx_prev_reg;
   wire ck_fall = ce_i & ~s_ckx & ckx_prev_reg;
   wire dqs_edg = ce_i & (s_dqs ^ dqs_prev_reg);
   wire run     = cke_q_reg;
   wire [3:0] blen = burst8_i ? `DSCI_BL8 : `DSCI_BL4;
   wire [2:0] al   = (add_lat_i > `DSCI_AL_MAX) ? `DSCI_AL_MAX : add_lat_i;
   wire [3:0] rl   = {1'b0, al} + {1'b0, cas_lat_i};
   wire [3:0] wl   = rl - 4'h1;
   wire       cmd_ok = ck_rise & run & ~s_cs_n;
   wire       last   = (beat_reg == blen - 4'h1);

   // Column order inside a burst, sequential wraps inside the burst block.
   wire [2:0] seq8 = col_reg + beat_reg[2:0];
   wire [2:0] seq4 = {col_reg[2], col_reg[1:0] + beat_reg[1:0]};
   wire [2:0] word = interleave_i ? (col_reg ^ beat_reg[2:0]) :
                     (burst8_i ? seq8 : seq4);

   // Two-flop synchroniser for every pin input except dqs_i[1].
   always @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         meta_reg <= {`DSCI_SYNC_W{1'b0}};
         sync_reg <= {`DSCI_SYNC_W{1'b0}};
      end else if (ce_i) begin
         meta_reg <= {ck_n_i, ck_i, cke_i, cs_n_i, ras_n_i, cas_n_i,
                      we_n_i, ba_i, addr_i, dqs_i[0], dm_i, dq_i};
         sync_reg <= meta_reg;
      end
   end

   // Edge history and clock enable capture at each rising crossing.
   always @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         ckx_prev_reg <= 1'b0;
         dqs_prev_reg <= 1'b0;
         cke_q_reg    <= 1'b0;
         suspended_o  <= 1'b1;
      end else if (ce_i) begin
         ckx_prev_reg <= s_ckx;
         dqs_prev_reg <= s_dqs;
         // [RULE11] [RULE19] suspend after CKE low
         if (ck_rise) begin
            cke_q_reg   <= s_cke;
            suspended_o <= ~s_cke;
         end
      end
   end

   // Power-down and self-refresh entry and exit.
   always @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         pdown_o <= 1'b0;
         sref_o  <= 1'b0;
      end else if (ck_rise) begin
         // [RULE12] idle entry selection
         if (run && !s_cke && bank_open_reg == 4'h0 &&
             state_reg == `DSCI_ST_IDLE) begin
            if (!s_cs_n && s_cmd == `DSCI_CMD_REF)
               sref_o <= 1'b1;
            else
               pdown_o <= 1'b1;
         end else if (s_cke) begin
            pdown_o <= 1'b0;
            sref_o  <= 1'b0;
         end
      end
   end

   // Per-bank open flag and row, one copy per bank.
   genvar b;
   generate
      for (b = 0; b < `DSCI_BANKS; b = b + 1) begin : g_bank
         wire sel = (s_ba == b);
         wire apc = ck_rise & run & (state_reg == `DSCI_ST_BURST) &
                    (beat_reg == blen) & is_rd_reg & ap_reg &
                    (bank_reg == b);
         wire apw = dqs_edg & run & (state_reg == `DSCI_ST_BURST) & last &
                    ~is_rd_reg & ap_reg & (bank_reg == b);
         always @(posedge sys_clk_i) begin
            if (!resetn_i) begin
               bank_open_reg[b] <= 1'b0;
               row_reg[b]       <= 13'h0000;
            // [RULE16] [RULE17] [RULE13] decode activate
            end else if (cmd_ok && s_cmd == `DSCI_CMD_ACT && sel) begin
               bank_open_reg[b] <= 1'b1;
               // [RULE18] [RULE4] full row address
               row_reg[b]       <= s_addr;
            // [RULE14] independent precharge per bank
            end else if (cmd_ok && s_cmd == `DSCI_CMD_PRE &&
                         (sel || s_addr[`DSCI_AP_BIT])) begin
               bank_open_reg[b] <= 1'b0;
            // [RULE8] self-timed close
            end else if (apc || apw) begin
               bank_open_reg[b] <= 1'b0;
            end
         end
      end
   endgenerate

   // Status mirror of the open banks.
   always @(posedge sys_clk_i) begin
      if (!resetn_i)
         bank_open_o <= 4'h0;
      else if (ce_i)
         bank_open_o <= bank_open_reg;
   end

   // Access sequencer: command capture, latency and burst beats.
   always @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         state_reg <= `DSCI_ST_IDLE;
         lat_reg   <= 4'h0;
         beat_reg  <= 4'h0;
         is_rd_reg <= 1'b0;
         ap_reg    <= 1'b0;
         bank_reg  <= 2'h0;
         col_reg   <= 3'h0;
         dq_o      <= 16'h0000;
         dq_oe_o   <= 1'b0;
         dqs_o     <= 2'h0;
         dqs_n_o   <= 2'h3;
         dqs_oe_o  <= 1'b0;
      end else begin
         case (state_reg)
            `DSCI_ST_IDLE: begin
               // [RULE5] only open banks accept access
               if (cmd_ok && (s_cmd == `DSCI_CMD_RD || s_cmd == `DSCI_CMD_WR)
                   && bank_open_reg[s_ba]) begin
                  is_rd_reg <= (s_cmd == `DSCI_CMD_RD);
                  // [RULE18] column and auto precharge
                  ap_reg    <= s_addr[`DSCI_AP_BIT];
                  bank_reg  <= s_ba;
                  col_reg   <= s_addr[2:0];
                  beat_reg  <= 4'h0;
                  // [RULE9] [RULE10] posted latency
                  lat_reg   <= (s_cmd == `DSCI_CMD_RD) ? rl : wl;
                  state_reg <= `DSCI_ST_WAIT;
               end
            end
            `DSCI_ST_WAIT: begin
               if (ck_rise && run) begin
                  lat_reg <= lat_reg - 4'h1;
                  if (lat_reg == 4'h1) begin
                     state_reg <= `DSCI_ST_BURST;
                     // [RULE2] [RULE3] first read beat on rise
                     if (is_rd_reg) begin
                        dq_o     <= mem_reg[word];
                        dq_oe_o  <= 1'b1;
                        dqs_o    <= 2'h3;
                        dqs_n_o  <= 2'h0;
                        dqs_oe_o <= 1'b1;
                        beat_reg <= 4'h1;
                     end
                  end
               end
            end
            `DSCI_ST_BURST: begin
               // [RULE11] beats frozen while suspended
               if (is_rd_reg && (ck_rise || ck_fall) && run) begin
                  // [RULE6] [RULE7] read burst beats
                  if (beat_reg == blen) begin
                     dq_oe_o   <= 1'b0;
                     dqs_oe_o  <= 1'b0;
                     dqs_o     <= 2'h0;
                     dqs_n_o   <= 2'h3;
                     state_reg <= `DSCI_ST_IDLE;
                  end else begin
                     dq_o     <= mem_reg[word];
                     dqs_o    <= {2{ck_rise}};
                     dqs_n_o  <= {2{ck_fall}};
                     beat_reg <= beat_reg + 4'h1;
                  end
               end else if (!is_rd_reg && dqs_edg && run) begin
                  // [RULE3] [RULE6] write beats on strobe edges
                  beat_reg <= beat_reg + 4'h1;
                  if (last)
                     state_reg <= `DSCI_ST_IDLE;
               end
            end
            default: state_reg <= `DSCI_ST_IDLE;
         endcase
      end
   end

   // Write storage, lanes masked by DM.
   genvar w;
   generate
      for (w = 0; w < `DSCI_WORDS; w = w + 1) begin : g_word
         wire wen = dqs_edg & run & (state_reg == `DSCI_ST_BURST) &
                    ~is_rd_reg & (word == w);
         always @(posedge sys_clk_i) begin
            if (!resetn_i) begin
               mem_reg[w] <= 16'h0000;
            end else if (wen) begin
               // [RULE7] ordered column write
               if (!s_dm[0])
                  mem_reg[w][7:0] <= s_dq[7:0];
               if (!s_dm[1])
                  mem_reg[w][15:8] <= s_dq[15:8];
            end
         end
      end
   endgenerate

endmodule // dsci_top
